/* File: common/soft_reset_pkg.sv */
/*
 * Constants, types and helpers for the peripheral soft-reset control block.
 * Assumes a 32-bit Avalon-MM register bus with byte addressing.
 */
package soft_reset_pkg;
  localparam int          DATA_W        = 32;
  localparam int          BE_W          = 4;
  localparam logic [11:0] OFFSET_CTRL_A = 12'h040;
  localparam logic [11:0] OFFSET_CTRL_B = 12'h044;
  localparam logic [31:0] RESET_CTRL    = 32'h00000000;
  localparam logic [31:0] IMPL_MASK_A   = 32'h00100048;
  localparam logic [31:0] IMPL_MASK_B   = 32'h070F4000;
  localparam logic [31:0] READ_UNMAPPED = 32'h00000000;
  localparam int          BIT_PWM       = 20;
  localparam int          BIT_HIB       = 6;
  localparam int          BIT_WDOG      = 3;
  localparam int          BIT_GPC0      = 16;
  localparam int          NUM_GPC       = 4;
  localparam int          BIT_CMP0      = 24;
  localparam int          NUM_CMP       = 3;
  localparam int          BIT_TWI1      = 14;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // only implemented, present bits in enabled byte lanes change
  function automatic logic [31:0] masked_write(
      input logic [31:0] old_val,
      input logic [31:0] wdata,
      input logic [3:0]  be,
      input logic [31:0] cap,
      input logic [31:0] impl);
    logic [31:0] m;
    m = lane_mask(be) & cap & impl;
    masked_write = (old_val & ~m) | (wdata & m);
  endfunction
endpackage

/* File: common/reg_access_if.sv */
/*
 * Carrier between the bus slave and the register bank.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
  logic        wr_strobe;
  logic        wr_sel_a;
  logic        wr_sel_b;
  logic [31:0] wr_data;
  logic [3:0]  wr_be;
  logic [31:0] ctrl_a;
  logic [31:0] ctrl_b;
  modport bus  (output wr_strobe, wr_sel_a, wr_sel_b, wr_data, wr_be,
                input  ctrl_a, ctrl_b);
  modport bank (input  wr_strobe, wr_sel_a, wr_sel_b, wr_data, wr_be,
                output ctrl_a, ctrl_b);
endinterface
`default_nettype wire

/* File: design/reset_release_sync.sv */
/*
 * Reset synchroniser: asynchronous assert, release after two clock edges.
 * Assumes the raw reset may change at any time.
 */
`timescale 1ns/1ps
`default_nettype none
module reset_release_sync (
  input  wire logic clk,     // system clock
  input  wire logic raw_n,   // raw active-low reset
  output logic      sync_n   // released active-low reset
);
  logic stage;

  always_ff @(posedge clk or negedge raw_n) begin
    if (!raw_n) begin
      stage  <= 1'b0;
      sync_n <= 1'b0;
    end else begin
      stage  <= 1'b1;
      sync_n <= stage;
    end
  end
endmodule
`default_nettype wire

/* File: design/avalon_reg_slave.sv */
/*
 * Avalon-MM slave: one wait cycle, then a single cycle with waitrequest low.
 * Assumes the master holds its request until waitrequest is sampled low.
 */
`timescale 1ns/1ps
`default_nettype none
module avalon_reg_slave
  import soft_reset_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk,            // system clock
  input  wire logic              rst_n,          // synchronised reset
  input  wire logic [ADDR_W-1:0] avs_address,    // byte address
  input  wire logic              avs_read,       // read request
  input  wire logic              avs_write,      // write request
  input  wire logic [31:0]       avs_writedata,  // write data
  input  wire logic [3:0]        avs_byteenable, // byte lanes
  output logic      [31:0]       avs_readdata,   // read data
  output logic                   avs_waitrequest,// stall
  reg_access_if.bus              acc             // register bank side
);
  bus_state_t state;
  logic       hit_a;
  logic       hit_b;

  if (ADDR_W < 7) begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end

  assign hit_a = (avs_address == ADDR_W'(OFFSET_CTRL_A));
  assign hit_b = (avs_address == ADDR_W'(OFFSET_CTRL_B));

  // write commits on the edge where the master sees waitrequest low
  assign acc.wr_strobe = (state == BUS_ACK) && avs_write;
  assign acc.wr_sel_a  = hit_a;
  assign acc.wr_sel_b  = hit_b;
  assign acc.wr_data   = avs_writedata;
  assign acc.wr_be     = avs_byteenable;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state           <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      unique case (state)
        BUS_IDLE: begin
          if (avs_read || avs_write) begin
            state           <= BUS_ACK;
            avs_waitrequest <= 1'b0;
          end
        end
        BUS_ACK: begin
          state           <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= READ_UNMAPPED;
    end else if (state == BUS_IDLE && avs_read) begin
      avs_readdata <= hit_a ? acc.ctrl_a :
                      hit_b ? acc.ctrl_b : READ_UNMAPPED;
    end
  end
endmodule
`default_nettype wire

/* File: design/peripheral_soft_reset_control.sv */
/*
 * Peripheral soft-reset control: two capability-gated control registers
 * whose bits hold individual peripherals in reset.
 * Assumes capability masks come from logic on the same clock and that
 * software reaches the registers over Avalon-MM.
 */
`timescale 1ns/1ps
`default_nettype none
module peripheral_soft_reset_control
  import soft_reset_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              mclk,              // system clock, 20 MHz
  input  wire logic              resetn,            // async system reset
  input  wire logic [ADDR_W-1:0] avs_address,       // byte address
  input  wire logic              avs_read,          // read request
  input  wire logic              avs_write,         // write request
  input  wire logic [31:0]       avs_writedata,     // write data
  input  wire logic [3:0]        avs_byteenable,    // byte lanes
  output logic      [31:0]       avs_readdata,      // read data
  output logic                   avs_waitrequest,   // stall
  input  wire logic [31:0]       capability_mask_a, // presence, reg A
  input  wire logic [31:0]       capability_mask_b, // presence, reg B
  output logic                   pwm_unit_reset,    // pwm held in reset
  output logic                   hibernate_unit_reset, // hibernation
  output logic                   watchdog_unit_reset,  // watchdog
  output logic                   gp_counter0_reset, // counter 0
  output logic                   gp_counter1_reset, // counter 1
  output logic                   gp_counter2_reset, // counter 2
  output logic                   gp_counter3_reset, // counter 3
  output logic                   comparator0_reset, // comparator 0
  output logic                   comparator1_reset, // comparator 1
  output logic                   comparator2_reset, // comparator 2
  output logic                   twowire_unit1_reset // two-wire unit 1
);
  logic        rst_n;
  logic [31:0] soft_reset_ctrl_a;
  logic [31:0] soft_reset_ctrl_b;

  reg_access_if acc ();

  if (ADDR_W < 7) begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end

  reset_release_sync u_rst (
    .clk    (mclk),
    .raw_n  (resetn),
    .sync_n (rst_n)
  );

  avalon_reg_slave #(
    .ADDR_W (ADDR_W)
  ) u_bus (
    .clk             (mclk),
    .rst_n           (rst_n),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .acc             (acc.bus)
  );

  assign acc.ctrl_a = soft_reset_ctrl_a;
  assign acc.ctrl_b = soft_reset_ctrl_b;

  // register A: pwm, hibernation, watchdog
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_ctrl_a <= RESET_CTRL;
    end else if (acc.wr_strobe && acc.wr_sel_a) begin
      soft_reset_ctrl_a <= masked_write(soft_reset_ctrl_a,
                                        acc.wr_data, acc.wr_be,
                                        capability_mask_a,
                                        IMPL_MASK_A);
    end
  end

  // register B: counters, comparators, two-wire unit 1
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_ctrl_b <= RESET_CTRL;
    end else if (acc.wr_strobe && acc.wr_sel_b) begin
      soft_reset_ctrl_b <= masked_write(soft_reset_ctrl_b,
                                        acc.wr_data, acc.wr_be,
                                        capability_mask_b,
                                        IMPL_MASK_B);
    end
  end

  // each peripheral is held while its bit is one
  assign pwm_unit_reset       = soft_reset_ctrl_a[BIT_PWM];
  assign hibernate_unit_reset = soft_reset_ctrl_a[BIT_HIB];
  assign watchdog_unit_reset  = soft_reset_ctrl_a[BIT_WDOG];
  assign gp_counter0_reset    = soft_reset_ctrl_b[BIT_GPC0];
  assign gp_counter1_reset    = soft_reset_ctrl_b[BIT_GPC0+1];
  assign gp_counter2_reset    = soft_reset_ctrl_b[BIT_GPC0+2];
  assign gp_counter3_reset    = soft_reset_ctrl_b[BIT_GPC0+3];
  assign comparator0_reset    = soft_reset_ctrl_b[BIT_CMP0];
  assign comparator1_reset    = soft_reset_ctrl_b[BIT_CMP0+1];
  assign comparator2_reset    = soft_reset_ctrl_b[BIT_CMP0+2];
  assign twowire_unit1_reset  = soft_reset_ctrl_b[BIT_TWI1];

  // helpers for the checks below
  logic [31:0] full_mask_a;
  logic [31:0] full_mask_b;
  logic        wr_a;
  logic        wr_b;
  logic [NUM_GPC-1:0] gpc_out;
  logic [NUM_CMP-1:0] cmp_out;

  assign full_mask_a = lane_mask(acc.wr_be) & capability_mask_a;
  assign full_mask_b = lane_mask(acc.wr_be) & capability_mask_b;
  assign wr_a        = acc.wr_strobe && acc.wr_sel_a;
  assign wr_b        = acc.wr_strobe && acc.wr_sel_b;
  assign gpc_out     = {gp_counter3_reset, gp_counter2_reset,
                        gp_counter1_reset, gp_counter0_reset};
  assign cmp_out     = {comparator2_reset, comparator1_reset,
                        comparator0_reset};

  sequence s_request;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  // bits without capability keep their value across a write
  property p_cap_gate_a;
    @(posedge mclk) disable iff (!rst_n)
      wr_a |=> ((soft_reset_ctrl_a ^ $past(soft_reset_ctrl_a))
                & ~$past(capability_mask_a)) == 32'h00000000;
  endproperty
  a_cap_gate_a: assert property (p_cap_gate_a)
    else $error("write changed a bit without capability in reg A");

  property p_cap_gate_b;
    @(posedge mclk) disable iff (!rst_n)
      wr_b |=> ((soft_reset_ctrl_b ^ $past(soft_reset_ctrl_b))
                & ~$past(capability_mask_b)) == 32'h00000000;
  endproperty
  a_cap_gate_b: assert property (p_cap_gate_b)
    else $error("write changed a bit without capability in reg B");

  // an enabled, present bit takes the written value
  property p_write_a;
    @(posedge mclk) disable iff (!rst_n)
      wr_a |=> ((soft_reset_ctrl_a ^ $past(acc.wr_data))
                & $past(full_mask_a) & IMPL_MASK_A) == 32'h00000000;
  endproperty
  a_write_a: assert property (p_write_a)
    else $error("reg A did not take the written value");

  property p_write_b;
    @(posedge mclk) disable iff (!rst_n)
      wr_b |=> ((soft_reset_ctrl_b ^ $past(acc.wr_data))
                & $past(full_mask_b) & IMPL_MASK_B) == 32'h00000000;
  endproperty
  a_write_b: assert property (p_write_b)
    else $error("reg B did not take the written value");

  // without a write both registers hold
  property p_hold;
    @(posedge mclk) disable iff (!rst_n)
      !acc.wr_strobe |=> $stable(soft_reset_ctrl_a)
                         && $stable(soft_reset_ctrl_b);
  endproperty
  a_hold: assert property (p_hold)
    else $error("control register changed without a write");

  // first cycle after reset release shows cleared registers
  property p_reset_clear;
    @(posedge mclk)
      $rose(rst_n) |-> soft_reset_ctrl_a == RESET_CTRL
                       && soft_reset_ctrl_b == RESET_CTRL;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("control registers not zero after reset");

  property p_reserved_zero;
    @(posedge mclk) disable iff (!rst_n)
      (soft_reset_ctrl_a & ~IMPL_MASK_A) == 32'h00000000
      && (soft_reset_ctrl_b & ~IMPL_MASK_B) == 32'h00000000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit reads as one");

  property p_pwm_follow;
    @(posedge mclk) disable iff (!rst_n)
      wr_a |=> pwm_unit_reset ==
        ($past(full_mask_a[BIT_PWM]) ? $past(acc.wr_data[BIT_PWM])
                                     : $past(pwm_unit_reset));
  endproperty
  a_pwm_follow: assert property (p_pwm_follow)
    else $error("pwm reset does not follow its write");

  property p_hib_wdog;
    @(posedge mclk) disable iff (!rst_n)
      hibernate_unit_reset == soft_reset_ctrl_a[BIT_HIB]
      && watchdog_unit_reset == soft_reset_ctrl_a[BIT_WDOG];
  endproperty
  a_hib_wdog: assert property (p_hib_wdog)
    else $error("hibernation or watchdog reset mismatch");

  property p_counters;
    @(posedge mclk) disable iff (!rst_n)
      gpc_out == soft_reset_ctrl_b[BIT_GPC0 +: NUM_GPC];
  endproperty
  a_counters: assert property (p_counters)
    else $error("counter reset outputs mismatch");

  property p_cmp_twi;
    @(posedge mclk) disable iff (!rst_n)
      cmp_out == soft_reset_ctrl_b[BIT_CMP0 +: NUM_CMP]
      && twowire_unit1_reset == soft_reset_ctrl_b[BIT_TWI1];
  endproperty
  a_cmp_twi: assert property (p_cmp_twi)
    else $error("comparator or two-wire reset mismatch");

  // clearing a bit releases its peripheral on the next cycle
  property p_release;
    @(posedge mclk) disable iff (!rst_n)
      wr_a && watchdog_unit_reset && full_mask_a[BIT_WDOG]
        && !acc.wr_data[BIT_WDOG] |=> !watchdog_unit_reset [*2];
  endproperty
  a_release: assert property (p_release)
    else $error("watchdog not released after clear");

  // one wait cycle, one answer cycle
  property p_bus_answer;
    @(posedge mclk) disable iff (!rst_n)
      s_request |=> s_answer;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer timing wrong");

  property p_read_data;
    @(posedge mclk) disable iff (!rst_n)
      avs_read && !avs_waitrequest |->
        avs_readdata == (acc.wr_sel_a ? soft_reset_ctrl_a :
                         acc.wr_sel_b ? soft_reset_ctrl_b :
                         READ_UNMAPPED);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data does not match register");

  // more helpers: lanes, misses and the full set of reset outputs
  logic [31:0]                lane_bits;
  logic                       wr_miss;
  logic [NUM_GPC+NUM_CMP+3:0] held_out;

  assign lane_bits = lane_mask(acc.wr_be);
  assign wr_miss   = acc.wr_strobe && !acc.wr_sel_a && !acc.wr_sel_b;
  assign held_out  = {pwm_unit_reset, hibernate_unit_reset,
                      watchdog_unit_reset, gpc_out, cmp_out,
                      twowire_unit1_reset};

  // bytes outside the enabled lanes keep their value
  property p_lane_gate;
    @(posedge mclk) disable iff (!rst_n)
      acc.wr_strobe |=>
        (((soft_reset_ctrl_a ^ $past(soft_reset_ctrl_a))
          | (soft_reset_ctrl_b ^ $past(soft_reset_ctrl_b)))
         & ~$past(lane_bits)) == 32'h00000000;
  endproperty
  a_lane_gate: assert property (p_lane_gate)
    else $error("write changed a byte lane that was not enabled");

  // a write to an unmapped address is dropped
  property p_miss_ignored;
    @(posedge mclk) disable iff (!rst_n)
      wr_miss |=> $stable(soft_reset_ctrl_a)
                  && $stable(soft_reset_ctrl_b);
  endproperty
  a_miss_ignored: assert property (p_miss_ignored)
    else $error("write to an unmapped address changed a register");

  // a write commits only in the cycle the master sees the answer
  property p_commit_on_answer;
    @(posedge mclk) disable iff (!rst_n)
      acc.wr_strobe |-> !avs_waitrequest && avs_write;
  endproperty
  a_commit_on_answer: assert property (p_commit_on_answer)
    else $error("write committed outside the answer cycle");

  // every peripheral leaves reset released and the bus idle
  property p_reset_outputs;
    @(posedge mclk)
      $rose(rst_n) |-> held_out == '0 && avs_waitrequest
                       && avs_readdata == READ_UNMAPPED;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs)
    else $error("peripheral reset or bus output wrong after reset");

  // a held peripheral stays held until a write to its register
  property p_pwm_held;
    @(posedge mclk) disable iff (!rst_n)
      pwm_unit_reset && !wr_a |=> pwm_unit_reset;
  endproperty
  a_pwm_held: assert property (p_pwm_held)
    else $error("pwm left reset without a write");

  // clearing counter 0: commit, then two cycles released
  sequence s_clear_gpc0;
    wr_b && gp_counter0_reset && full_mask_b[BIT_GPC0]
      && !acc.wr_data[BIT_GPC0];
  endsequence

  property p_release_gpc0;
    @(posedge mclk) disable iff (!rst_n)
      s_clear_gpc0 |=> !gp_counter0_reset [*2];
  endproperty
  a_release_gpc0: assert property (p_release_gpc0)
    else $error("counter 0 not released after clear");
endmodule
`default_nettype wire

/* File: tb/peripheral_soft_reset_control_tb.sv */
/*
 * Self-checking bench for the peripheral soft-reset control block.
 * Assumes the design files and soft_reset_pkg are compiled first; the
 * bench is the only Avalon-MM master and drives the capability masks.
 */
`timescale 1ns/1ps
`default_nettype none
module peripheral_soft_reset_control_tb;
  import soft_reset_pkg::*;

  logic        mclk           = 1'b0;
  logic        resetn;
  logic [11:0] avs_address    = 12'h000;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [31:0] avs_writedata  = 32'h00000000;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] cap_a          = 32'h00000000;
  logic [31:0] cap_b          = 32'h00000000;
  logic        pwm_r, hib_r, wdog_r, twi_r;
  logic [3:0]  gpc_r;
  logic [2:0]  cmp_r;
  logic [31:0] exp_a          = 32'h00000000;
  logic [31:0] exp_b          = 32'h00000000;
  logic [31:0] rnd            = 32'h0000DB41;
  logic [31:0] rd;
  int          bad_count      = 0;
  int          checked        = 0;

  peripheral_soft_reset_control #(.ADDR_W(12)) dut_u (
    .mclk(mclk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .capability_mask_a(cap_a), .capability_mask_b(cap_b),
    .pwm_unit_reset(pwm_r), .hibernate_unit_reset(hib_r),
    .watchdog_unit_reset(wdog_r), .gp_counter0_reset(gpc_r[0]),
    .gp_counter1_reset(gpc_r[1]), .gp_counter2_reset(gpc_r[2]),
    .gp_counter3_reset(gpc_r[3]), .comparator0_reset(cmp_r[0]),
    .comparator1_reset(cmp_r[1]), .comparator2_reset(cmp_r[2]),
    .twowire_unit1_reset(twi_r)
  );

  initial begin
    forever #25 mclk = ~mclk;
  end

  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction

  // expected register value after a write, bit by bit
  function automatic logic [31:0] model_wr(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be,
      input logic [31:0] cap, input logic [31:0] impl);
    logic [31:0] m;
    for (int i = 0; i < 32; i++) begin
      m[i] = be[i / 8] & cap[i] & impl[i];
    end
    return (old & ~m) | (wd & m);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // waits for waitrequest sampled low; read data taken at that edge
  task automatic bus_wait(output logic [31:0] data);
    int n;
    n = 0;
    data = 32'h00000000;
    forever begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0) begin
        data = avs_readdata;
        break;
      end
      n++;
      if (n > 50) begin
        bad_count++;
        $display("[ERR] %0t: no bus answer", $time);
        test_done();
      end
    end
  endtask

  task automatic bus_write(input logic [11:0] a, input logic [31:0] d,
                           input logic [3:0] be);
    logic [31:0] dummy;
    @(posedge mclk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= 1'b1;
    bus_wait(dummy);
    avs_write      <= 1'b0;
    if (a === OFFSET_CTRL_A) begin
      exp_a = model_wr(exp_a, d, be, cap_a, IMPL_MASK_A);
    end else if (a === OFFSET_CTRL_B) begin
      exp_b = model_wr(exp_b, d, be, cap_b, IMPL_MASK_B);
    end
  endtask

  task automatic bus_read(input logic [11:0] a, output logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_read    <= 1'b1;
    bus_wait(d);
    avs_read    <= 1'b0;
  endtask

  function automatic logic [31:0] exp_of(input logic [11:0] a);
    if (a == OFFSET_CTRL_A) return exp_a;
    if (a == OFFSET_CTRL_B) return exp_b;
    return READ_UNMAPPED;
  endfunction

  // compare both registers and every peripheral reset level
  task automatic check_all();
    @(negedge mclk);
    check(32'({pwm_r, hib_r, wdog_r}), 32'({exp_a[BIT_PWM], exp_a[BIT_HIB],
          exp_a[BIT_WDOG]}));
    check(32'({cmp_r, gpc_r, twi_r}), 32'({exp_b[BIT_CMP0 +: NUM_CMP],
          exp_b[BIT_GPC0 +: NUM_GPC], exp_b[BIT_TWI1]}));
    bus_read(OFFSET_CTRL_A, rd);
    check(rd, exp_a);
    bus_read(OFFSET_CTRL_B, rd);
    check(rd, exp_b);
  endtask

  task automatic do_reset();
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (5) @(posedge mclk);
    check(32'(avs_waitrequest), 32'h00000001);
    exp_a = RESET_CTRL;
    exp_b = RESET_CTRL;
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    check_all();
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    $display("[ERR] %0t: watchdog expired", $time);
    test_done();
  end

  initial begin
    logic [11:0] addrs [4];
    addrs = '{OFFSET_CTRL_A, OFFSET_CTRL_B, 12'h048, 12'h042};
    resetn <= 1'b0;
    do_reset();
    $display("test reset values done");
    // all present: every implemented bit set, reserved bits stay zero
    cap_a <= 32'hFFFFFFFF;
    cap_b <= 32'hFFFFFFFF;
    bus_write(OFFSET_CTRL_A, 32'hFFFFFFFF, 4'hF);
    bus_write(OFFSET_CTRL_B, 32'hFFFFFFFF, 4'hF);
    check_all();
    // absent peripherals cannot be cleared
    cap_a <= 32'h00000000;
    cap_b <= 1 << BIT_GPC0;
    bus_write(OFFSET_CTRL_A, 32'h00000000, 4'hF);
    bus_write(OFFSET_CTRL_B, 32'h00000000, 4'hF);
    check_all();
    check(rd, IMPL_MASK_B & ~(32'h1 << BIT_GPC0));
    // disabled lanes and unmapped addresses change nothing
    cap_a <= 32'hFFFFFFFF;
    cap_b <= 32'hFFFFFFFF;
    bus_write(OFFSET_CTRL_A, 32'h00000000, 4'hB);
    bus_write(12'h048, 32'h00000000, 4'hF);
    bus_write(12'h041, 32'h00000000, 4'hF);
    check_all();
    bus_read(12'h048, rd);
    check(rd, READ_UNMAPPED);
    $display("test directed corners done");
    for (int i = 0; i < 60; i++) begin
      cap_a <= xs();
      cap_b <= xs();
      bus_write(addrs[xs() % 4], xs(), 4'(xs()));
      if (i % 4 == 0) begin
        check_all();
      end
      bus_read(addrs[i % 4], rd);
      check(rd, exp_of(addrs[i % 4]));
    end
    $display("test random traffic done");
    do_reset();
    $display("test mid-run reset done");
    test_done();
  end
endmodule
`default_nettype wire
